// ---- pmr_map.svh ----
// Function
// - Writing one to the soft reset bit returns every other register bit to its default and power-cycles the regulator outputs.
// - The soft reset bit clears itself during the reset action, defaults to zero and always reads back zero.
// - A two-bit read/write field picks the long ON-key press time (00 4 s, 01 8 s, 10 12 s, 11 16 s) and defaults to 01.
// - The watchdog kick register at 0Dh is write-only, with five reserved upper bits defaulting to 00000 and a three-bit clear field below.
// - Writing code 001 into the watchdog clear field restarts the watchdog timer.
// - Any other code in the watchdog clear field leaves the watchdog alone, and the field defaults to 000.
// - The charger control register at 10h is read/write and holds the five-bit charger write guard in bits 7 to 3, defaulting to 00000.
// - While the charger write guard holds exactly 10101, writes to the guarded registers are accepted.
// - While the charger write guard holds any other value, writes to the guarded registers are dropped and their contents kept.
// - Bit 2 of the charger control register enables thermistor control when 1, disables it when 0, and defaults to 0.
// - Bit 1 of the charger control register turns the fast-charge and pre-qualification timers on when 1, off when 0, and defaults to 1.
// - Bit 0 of the charger control register enables the linear battery charger when 1, disables it when 0, and defaults to 1.
// - The charger current register at 11h is one of the registers guarded by the charger write guard.
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH

// register byte offsets
`define PMR_ADDR_CTL3 8'h0c
`define PMR_ADDR_WDOG 8'h0d
`define PMR_ADDR_CHG0 8'h10
`define PMR_ADDR_CHG1 8'h11

// top control 3 fields
`define PMR_SRST_BIT 2
`define PMR_GLT_MSB 1
`define PMR_GLT_LSB 0
`define PMR_GLT_RST 2'h1
`define PMR_CTL3_PAD 6'h00

// watchdog kick fields
`define PMR_WDOG_MSB 2
`define PMR_WDOG_LSB 0
`define PMR_WDOG_KICK 3'h1

// charger control 0 fields
`define PMR_LOCK_MSB 7
`define PMR_LOCK_LSB 3
`define PMR_LOCK_KEY 5'h15
`define PMR_LOCK_RST 5'h00
`define PMR_NTC_BIT 2
`define PMR_NTC_RST 1'h0
`define PMR_TMR_BIT 1
`define PMR_TMR_RST 1'h1
`define PMR_CHGEN_BIT 0
`define PMR_CHGEN_RST 1'h1

// charger current register reset value
`define PMR_CHG1_RST 8'h08
`define PMR_RD_ZERO 8'h00

// regulator off time during a soft reset, rounded up to clock cycles
`define PMR_CLK_NS 4
`define PMR_PWR_OFF_NS 1000
`define PMR_PWR_OFF_CYC ((`PMR_PWR_OFF_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)

`endif

// ---- pmr_pkg.sv ----
package pmr_pkg;
  // soft reset sequencer states, one-hot
  typedef enum logic [2:0] {
    PMR_IDLE = 3'b001,
    PMR_CLEAR = 3'b010,
    PMR_OFF = 3'b100
  } pmr_seq_state_t;
  typedef logic [7:0] pmr_byte_t;
endpackage : pmr_pkg

// ---- pmr_guard_reg.sv ----
`include "pmr_map.svh"
// one register whose writes only land while the charger guard is open
module pmr_guard_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic clear, // soft reset, restores default
  input wire logic wr, // write strobe for this register
  input wire logic open, // guard holds the unlock key
  input wire logic [WIDTH-1:0] wdata, // write data
  output logic [WIDTH-1:0] value // stored contents
);
  logic [WIDTH-1:0] next_value;

  // soft reset wins over a write in the same cycle
  always_comb begin
    next_value = value;
    if (clear) begin
      next_value = RESET_VALUE;
    end else if (wr && open) begin
      next_value = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end

  a_locked_keep: assert property (@(posedge clk) disable iff (rst)
    wr && !open && !clear |=> $stable(value))
    else $error("locked write changed guarded register");
endmodule : pmr_guard_reg

// ---- pmr_reset_seq.sv ----
`include "pmr_map.svh"
// soft reset sequencer: one clear pulse, then the regulators held off
module pmr_reset_seq
  import pmr_pkg::*;
#(
  parameter int OFF_CYCLES = `PMR_PWR_OFF_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic start, // soft reset requested
  output logic clear_pulse, // one cycle, resets other banks
  output logic power_off // regulators held off
);
  localparam int CW = $clog2(OFF_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(OFF_CYCLES - 1);

  pmr_seq_state_t state;
  pmr_seq_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // a new request during the off time restarts the whole sequence
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      PMR_IDLE: begin
        if (start) begin
          next_state = PMR_CLEAR;
        end
      end
      PMR_CLEAR: begin
        next_state = PMR_OFF;
        next_cnt = CNT_LAST;
      end
      PMR_OFF: begin
        if (start) begin
          next_state = PMR_CLEAR;
        end else if (cnt == '0) begin
          next_state = PMR_IDLE;
        end else begin
          next_cnt = cnt - CW'(1);
        end
      end
      default: begin
        next_state = PMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PMR_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign clear_pulse = state[1];
  assign power_off = state[2];

  a_off_follows: assert property (@(posedge clk) disable iff (rst)
    clear_pulse |=> power_off)
    else $error("regulators not cycled after soft reset");
endmodule : pmr_reset_seq

// ---- pmr_top.sv ----
`include "pmr_map.svh"
// top control tail, watchdog kick and charger control registers
module pmr_top
  import pmr_pkg::*;
#(
  parameter int OFF_CYCLES = `PMR_PWR_OFF_CYC
) (
  input wire logic REF_CLK, // 250 MHz system clock
  input wire logic RST, // sync reset, active high
  input wire logic REG_WR, // byte write strobe from i2c slave
  input wire logic REG_RD, // byte read strobe from i2c slave
  input wire pmr_pkg::pmr_byte_t REG_ADDR, // register offset
  input wire pmr_pkg::pmr_byte_t REG_WDATA, // write data
  output pmr_pkg::pmr_byte_t REG_RDATA, // read data, valid with REG_RVALID
  output logic REG_RVALID, // read answer pulse
  output logic [1:0] LONG_PRESS_SEL, // key long press time code
  output logic WDOG_RESTART, // watchdog restart pulse
  output logic CHG_GUARD_OPEN, // guard holds the unlock key
  output logic THERM_EN, // thermistor control enable
  output logic TIMERS_EN, // charge timers enable
  output logic CHARGER_EN, // linear charger enable
  output pmr_pkg::pmr_byte_t CHG_CURRENT_REG, // guarded charger current register
  output logic REGS_RESET, // one-cycle reset to other banks
  output logic REG_POWER_OFF // regulators held off
);
  import pmr_pkg::*;

  // address match, used by every write strobe decode
  function automatic logic hit(input pmr_byte_t addr, input pmr_byte_t target);
    return addr == target;
  endfunction : hit

  logic [1:0] key_long_press_time_sel;
  logic [1:0] next_key_long_press_time_sel;
  logic [4:0] charger_write_guard;
  logic [4:0] next_charger_write_guard;
  logic guard_open;
  logic next_guard_open;
  logic thermistor_control_enable;
  logic next_thermistor_control_enable;
  logic charge_timers_enable;
  logic next_charge_timers_enable;
  logic battery_charger_enable;
  logic next_battery_charger_enable;
  logic wdog_kick;
  logic next_wdog_kick;
  pmr_byte_t rdata;
  pmr_byte_t next_rdata;
  logic rvalid;
  logic next_rvalid;
  pmr_byte_t charger_current_register;
  logic wr_ctl3;
  logic wr_wdog;
  logic wr_chg0;
  logic wr_chg1;
  logic soft_reset_bit;
  logic [2:0] watchdog_clear_code;
  logic regs_clear;
  logic pwr_off;

  // strobe decode; the i2c slave gives one strobe per byte
  assign wr_ctl3 = REG_WR && hit(REG_ADDR, `PMR_ADDR_CTL3);
  assign wr_wdog = REG_WR && hit(REG_ADDR, `PMR_ADDR_WDOG);
  assign wr_chg0 = REG_WR && hit(REG_ADDR, `PMR_ADDR_CHG0);
  assign wr_chg1 = REG_WR && hit(REG_ADDR, `PMR_ADDR_CHG1);
  // zero written here is no request
  assign soft_reset_bit = wr_ctl3 && REG_WDATA[`PMR_SRST_BIT];
  assign watchdog_clear_code = REG_WDATA[`PMR_WDOG_MSB:`PMR_WDOG_LSB];

  // register next values; soft reset outranks any write in its cycle
  always_comb begin
    next_key_long_press_time_sel = key_long_press_time_sel;
    next_charger_write_guard = charger_write_guard;
    next_thermistor_control_enable = thermistor_control_enable;
    next_charge_timers_enable = charge_timers_enable;
    next_battery_charger_enable = battery_charger_enable;
    if (soft_reset_bit) begin
      next_key_long_press_time_sel = `PMR_GLT_RST;
      next_charger_write_guard = `PMR_LOCK_RST;
      next_thermistor_control_enable = `PMR_NTC_RST;
      next_charge_timers_enable = `PMR_TMR_RST;
      next_battery_charger_enable = `PMR_CHGEN_RST;
    end else begin
      if (wr_ctl3) begin
        next_key_long_press_time_sel = REG_WDATA[`PMR_GLT_MSB:`PMR_GLT_LSB];
      end
      if (wr_chg0) begin
        next_charger_write_guard = REG_WDATA[`PMR_LOCK_MSB:`PMR_LOCK_LSB];
        next_thermistor_control_enable = REG_WDATA[`PMR_NTC_BIT];
        next_charge_timers_enable = REG_WDATA[`PMR_TMR_BIT];
        next_battery_charger_enable = REG_WDATA[`PMR_CHGEN_BIT];
      end
    end
    // open flag tracks the stored key
    next_guard_open = next_charger_write_guard == `PMR_LOCK_KEY;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      key_long_press_time_sel <= `PMR_GLT_RST;
      charger_write_guard <= `PMR_LOCK_RST;
      guard_open <= 1'b0;
      thermistor_control_enable <= `PMR_NTC_RST;
      charge_timers_enable <= `PMR_TMR_RST;
      battery_charger_enable <= `PMR_CHGEN_RST;
    end else begin
      key_long_press_time_sel <= next_key_long_press_time_sel;
      charger_write_guard <= next_charger_write_guard;
      guard_open <= next_guard_open;
      thermistor_control_enable <= next_thermistor_control_enable;
      charge_timers_enable <= next_charge_timers_enable;
      battery_charger_enable <= next_battery_charger_enable;
    end
  end

  // watchdog kick: the field is never stored, only the matching code acts
  always_comb begin
    next_wdog_kick = wr_wdog && (watchdog_clear_code == `PMR_WDOG_KICK);
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wdog_kick <= 1'b0;
    end else begin
      wdog_kick <= next_wdog_kick;
    end
  end

  // read path; reads see the value before a same-cycle write lands
  always_comb begin
    next_rvalid = REG_RD;
    next_rdata = `PMR_RD_ZERO;
    if (REG_RD) begin
      case (REG_ADDR)
        `PMR_ADDR_CTL3: begin
          next_rdata = {`PMR_CTL3_PAD, key_long_press_time_sel};
        end
        `PMR_ADDR_WDOG: begin
          next_rdata = `PMR_RD_ZERO;
        end
        `PMR_ADDR_CHG0: begin
          next_rdata = {charger_write_guard, thermistor_control_enable,
                        charge_timers_enable, battery_charger_enable};
        end
        `PMR_ADDR_CHG1: begin
          next_rdata = charger_current_register;
        end
        default: begin
          next_rdata = `PMR_RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rvalid <= 1'b0;
      rdata <= `PMR_RD_ZERO;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
    end
  end

  pmr_guard_reg #(
    .WIDTH(8),
    .RESET_VALUE(`PMR_CHG1_RST)
  ) u_chg1 (
    .clk(REF_CLK),
    .rst(RST),
    .clear(soft_reset_bit),
    .wr(wr_chg1),
    .open(guard_open),
    .wdata(REG_WDATA),
    .value(charger_current_register)
  );

  pmr_reset_seq #(
    .OFF_CYCLES(OFF_CYCLES)
  ) u_seq (
    .clk(REF_CLK),
    .rst(RST),
    .start(soft_reset_bit),
    .clear_pulse(regs_clear),
    .power_off(pwr_off)
  );

  // every output is a flop, here or inside the two submodules
  assign REG_RDATA = rdata;
  assign REG_RVALID = rvalid;
  assign LONG_PRESS_SEL = key_long_press_time_sel;
  assign WDOG_RESTART = wdog_kick;
  assign CHG_GUARD_OPEN = guard_open;
  assign THERM_EN = thermistor_control_enable;
  assign TIMERS_EN = charge_timers_enable;
  assign CHARGER_EN = battery_charger_enable;
  assign CHG_CURRENT_REG = charger_current_register;
  assign REGS_RESET = regs_clear;
  assign REG_POWER_OFF = pwr_off;

  // length of the current power-off run; a counter keeps the property
  // short where a repetition of OFF_CYCLES would not unroll
  localparam int RW = $clog2(OFF_CYCLES + 2);
  localparam logic [RW-1:0] RUN_FULL = RW'(OFF_CYCLES);
  logic [RW-1:0] off_run;
  logic [RW-1:0] next_off_run;

  always_comb begin
    next_off_run = '0;
    if (pwr_off) begin
      next_off_run = off_run + RW'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      off_run <= '0;
    end else begin
      off_run <= next_off_run;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // defaults land one edge after the request, clear pulse with them
  a_srst_defaults: assert property (soft_reset_bit |=>
    LONG_PRESS_SEL == `PMR_GLT_RST && CHARGER_EN && TIMERS_EN && !THERM_EN
    && !CHG_GUARD_OPEN && REGS_RESET && CHG_CURRENT_REG == `PMR_CHG1_RST)
    else $error("soft reset did not restore defaults");

  a_srst_read_zero: assert property (REG_RD && hit(REG_ADDR, `PMR_ADDR_CTL3) |=>
    REG_RVALID && !REG_RDATA[`PMR_SRST_BIT])
    else $error("soft reset bit read back nonzero");

  a_press_time: assert property (wr_ctl3 && !soft_reset_bit |=>
    LONG_PRESS_SEL == $past(REG_WDATA[`PMR_GLT_MSB:`PMR_GLT_LSB]))
    else $error("press time field not written");

  a_wdog_readback: assert property (REG_RD && hit(REG_ADDR, `PMR_ADDR_WDOG) |=>
    REG_RVALID && REG_RDATA == `PMR_RD_ZERO)
    else $error("watchdog register read nonzero");

  a_wdog_kick: assert property (wr_wdog && watchdog_clear_code == `PMR_WDOG_KICK |=>
    WDOG_RESTART ##1 (WDOG_RESTART == $past(wr_wdog
    && watchdog_clear_code == `PMR_WDOG_KICK)))
    else $error("watchdog kick missing");

  a_wdog_cause: assert property (WDOG_RESTART |->
    $past(wr_wdog) && $past(watchdog_clear_code) == `PMR_WDOG_KICK)
    else $error("watchdog restart without code 001");

  a_guard_store: assert property (wr_chg0 && !soft_reset_bit |=>
    CHG_GUARD_OPEN == ($past(REG_WDATA[`PMR_LOCK_MSB:`PMR_LOCK_LSB])
    == `PMR_LOCK_KEY))
    else $error("guard field not stored");

  a_chg0_readback: assert property (REG_RD && hit(REG_ADDR, `PMR_ADDR_CHG0) |=>
    REG_RDATA == $past({charger_write_guard, THERM_EN, TIMERS_EN, CHARGER_EN}))
    else $error("charger control read mismatch");

  a_guard_accept: assert property (wr_chg1 && CHG_GUARD_OPEN && !soft_reset_bit |=>
    CHG_CURRENT_REG == $past(REG_WDATA))
    else $error("open guard refused a write");

  a_guard_reject: assert property (wr_chg1 && !CHG_GUARD_OPEN && !soft_reset_bit |=>
    CHG_CURRENT_REG == $past(CHG_CURRENT_REG))
    else $error("closed guard let a write through");

  a_therm_bit: assert property (wr_chg0 && !soft_reset_bit |=>
    THERM_EN == $past(REG_WDATA[`PMR_NTC_BIT]))
    else $error("thermistor enable not written");

  a_timer_bit: assert property (wr_chg0 && !soft_reset_bit |=>
    TIMERS_EN == $past(REG_WDATA[`PMR_TMR_BIT]))
    else $error("timers enable not written");

  a_charger_bit: assert property (wr_chg0 && !soft_reset_bit |=>
    CHARGER_EN == $past(REG_WDATA[`PMR_CHGEN_BIT]))
    else $error("charger enable not written");

  a_guard_target: assert property (REG_RD && hit(REG_ADDR, `PMR_ADDR_CHG1) |=>
    REG_RDATA == $past(CHG_CURRENT_REG))
    else $error("guarded register read mismatch");

  a_zero_no_reset: assert property (wr_ctl3 && !REG_WDATA[`PMR_SRST_BIT] && !REGS_RESET
    && !REG_POWER_OFF |=> !REGS_RESET)
    else $error("zero write triggered soft reset");

  // an off run ends only at its full length, or when a new request restarts it
  a_power_len: assert property (!REG_POWER_OFF && !REGS_RESET && off_run != '0 |->
    off_run == RUN_FULL)
    else $error("regulator off time wrong length");

  // main scenarios
  c_soft_reset: cover property (soft_reset_bit ##1 REGS_RESET ##1 REG_POWER_OFF);
  c_wdog_kick: cover property (WDOG_RESTART);
  c_guard_accept: cover property (wr_chg1 && CHG_GUARD_OPEN);
  c_guard_reject: cover property (wr_chg1 && !CHG_GUARD_OPEN);
  c_power_done: cover property ($fell(REG_POWER_OFF));
endmodule : pmr_top

// ---- pmr_host.sv ----
// host side of the register byte port, as seen behind the bus slave
module pmr_host (
  input wire logic clk, // system clock
  output logic wr, // byte write strobe
  output logic rd, // byte read strobe
  output pmr_pkg::pmr_byte_t addr, // register offset
  output pmr_pkg::pmr_byte_t wdata, // write data
  input wire pmr_pkg::pmr_byte_t rdata, // read data
  input wire logic rvalid // read answer pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  import pmr_pkg::*;
  // idle edges before each request, raised to play a slow host
  int gap = 0;
  // strobes idle low from time zero
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // one strobe edge per byte; the idle bus is scrambled so stale values never pass
  task automatic write_reg(input pmr_byte_t a, input pmr_byte_t d);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : write_reg
  // the answer stands for one cycle only, so it is taken just after the edge
  task automatic read_reg(input pmr_byte_t a, output pmr_byte_t d, output logic ok);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    ok = rvalid;
    d = rdata;
  endtask : read_reg
endmodule : pmr_host

// ---- pmic_top_and_charger_control_regs_tb.sv ----
module pmic_top_and_charger_control_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pmr_pkg::*;
  // short off time keeps the soft reset walk brief
  localparam int OFF = 4;
  logic ref_clk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  pmr_byte_t reg_addr;
  pmr_byte_t reg_wdata;
  pmr_byte_t reg_rdata;
  logic reg_rvalid;
  logic [1:0] long_sel;
  logic wdog;
  logic guard_open;
  logic therm_en;
  logic timers_en;
  logic charger_en;
  pmr_byte_t chg_cur;
  logic regs_reset;
  logic power_off;
  pmr_byte_t rd_data;
  logic rd_ok;
  int n;
  int fails = 0;
  int checks = 0;
  // 250 MHz clock
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  pmr_top #(.OFF_CYCLES(OFF)) i_pmr_top (
    .REF_CLK(ref_clk),
    .RST(rst),
    .REG_WR(reg_wr),
    .REG_RD(reg_rd),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid),
    .LONG_PRESS_SEL(long_sel),
    .WDOG_RESTART(wdog),
    .CHG_GUARD_OPEN(guard_open),
    .THERM_EN(therm_en),
    .TIMERS_EN(timers_en),
    .CHARGER_EN(charger_en),
    .CHG_CURRENT_REG(chg_cur),
    .REGS_RESET(regs_reset),
    .REG_POWER_OFF(power_off)
  );
  pmr_host i_pmr_host (
    .clk(ref_clk),
    .wr(reg_wr),
    .rd(reg_rd),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .rdata(reg_rdata),
    .rvalid(reg_rvalid)
  );
  // compare two bytes; unknown bits never match
  task automatic chk(input pmr_byte_t got, input pmr_byte_t exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read and compare, the answer pulse included
  task automatic rd_chk(input pmr_byte_t a, input pmr_byte_t exp);
    i_pmr_host.read_reg(a, rd_data, rd_ok);
    chk({7'h00, rd_ok}, 8'h01);
    chk(rd_data, exp);
  endtask : rd_chk
  // write, then let the taking edge land before anything is looked at
  task automatic wr_reg(input pmr_byte_t a, input pmr_byte_t d);
    i_pmr_host.write_reg(a, d);
    #1;
  endtask : wr_reg
  // guard flag, three charger enables and the guarded register
  task automatic chk_chg(input logic [3:0] bits, input pmr_byte_t cur);
    chk({4'h0, guard_open, therm_en, timers_en, charger_en}, {4'h0, bits});
    chk(chg_cur, cur);
  endtask : chk_chg
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk_chg(4'b0011, 8'h08);
    chk({4'h0, regs_reset, power_off, long_sel}, 8'h01);
    rd_chk(8'h0c, 8'h01);
    rd_chk(8'h10, 8'h03);
    rd_chk(8'h0d, 8'h00);
    rd_chk(8'h0e, 8'h00);
    wr_reg(8'h0f, 8'hff);
    chk_chg(4'b0011, 8'h08);
    $display("test defaults done");
    // every press time code, soft reset bit left at zero
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h0c, 8'(s));
      chk({6'h00, long_sel}, 8'(s));
      chk({6'h00, regs_reset, power_off}, 8'h00);
      rd_chk(8'h0c, 8'(s));
    end
    $display("test press time done");
    // only code 001 restarts, upper bits set throughout
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h0d, 8'hf8 | 8'(c));
      chk({7'h00, wdog}, {7'h00, c == 1});
      @(posedge ref_clk);
      #1;
      chk({7'h00, wdog}, 8'h00);
    end
    rd_chk(8'h0d, 8'h00);
    $display("test watchdog done");
    // guard shut, one bit short, then open
    wr_reg(8'h11, 8'h3f);
    chk_chg(4'b0011, 8'h08);
    wr_reg(8'h10, 8'ha7);
    chk_chg(4'b0111, 8'h08);
    wr_reg(8'h11, 8'h3f);
    chk_chg(4'b0111, 8'h08);
    rd_chk(8'h10, 8'ha7);
    for (int b = 0; b < 8; b++) begin
      wr_reg(8'h10, 8'ha8 | 8'(b));
      chk_chg({1'b1, 3'(b)}, 8'h08);
    end
    wr_reg(8'h11, 8'h3f);
    chk_chg(4'b1111, 8'h3f);
    rd_chk(8'h11, 8'h3f);
    // a slow host must not matter to the guard
    i_pmr_host.gap = 3;
    wr_reg(8'h11, 8'h2a);
    i_pmr_host.gap = 0;
    chk_chg(4'b1111, 8'h2a);
    wr_reg(8'h10, 8'h05);
    chk_chg(4'b0101, 8'h2a);
    wr_reg(8'h11, 8'h11);
    chk_chg(4'b0101, 8'h2a);
    $display("test guard done");
    // soft reset restores defaults, then holds regulators off
    wr_reg(8'h10, 8'haa);
    wr_reg(8'h11, 8'h30);
    wr_reg(8'h0c, 8'h07);
    chk_chg(4'b0011, 8'h08);
    chk({4'h0, regs_reset, power_off, long_sel}, 8'h09);
    n = 0;
    for (int i = 0; i < 4 * OFF; i++) begin
      @(posedge ref_clk);
      #1;
      if (power_off === 1'b1) begin
        n++;
      end
    end
    chk(8'(n), 8'(OFF));
    chk({7'h00, regs_reset}, 8'h00);
    rd_chk(8'h0c, 8'h01);
    rd_chk(8'h10, 8'h03);
    $display("test soft reset done");
    // a mid-run reset returns every field to its default
    wr_reg(8'h0c, 8'h03);
    wr_reg(8'h10, 8'haf);
    wr_reg(8'h11, 8'h3f);
    chk_chg(4'b1111, 8'h3f);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk_chg(4'b0011, 8'h08);
    chk({4'h0, regs_reset, power_off, long_sel}, 8'h01);
    rd_chk(8'h10, 8'h03);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : pmic_top_and_charger_control_regs_tb
